// ### verilog/cvo_stage.sv
// Composite and component output stage: shaping, sync, chroma modulation,
// VBI insertion and DAC formatting. Timing and scaled video come from upstream.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module cvo_stage
    import cvo_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire bus_req_t    bus,
    output logic [15:0]      rdata,
    input  wire vid_in_t     vin,
    input  wire timing_t     tim,
    output logic [29:0]      dac_code,
    output logic [2:0]       dac_power_down_bits,
    output logic [13:0]      vbi_word,
    output logic             vbi_valid,
    output logic [7:0]       cap_byte,
    output logic             cap_valid
);
    logic [15:0] cvbs_r, subcarrier_program_reg_r, video_mode_reg_r, amp_r, test_r, sel_r, component_control_reg_r;
    logic [15:0] attribute_word_low_r, attribute_word_high_r, attribute_crc_enable_r, caption_control_reg_r;
    logic [6:0]  caption_odd_data, caption_even_data;
    logic        caption_odd_pending, caption_even_pending;
    logic        phase_pend_r;
    logic [9:0]  phase_r;
    logic [13:0] attr_lat_r;
    logic [5:0]  bld_cnt_r;
    logic [9:0]  luma_pipe_r [0:7];
    logic [9:0]  c_mod, y_cvbs, y_cmp, y_shaped, c_shaped, sv_c;
    logic        blank_d_r;
    logic [9:0]  dac_src [0:2];
    logic        wr_attribute_crc_enable, line_go;
    ins_state_t  ins_r;

    assign wr_attribute_crc_enable = bus.wr && bus.addr == A_ATTRIBUTE_CRC_ENABLE;
    assign line_go = tim.line_start;

    // Register writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cvbs_r   <= '0;
            subcarrier_program_reg_r <= '0;
            video_mode_reg_r   <= '0;
            amp_r    <= {6'h00, GAIN_RST};
            test_r   <= '0;
            sel_r    <= '0;
            component_control_reg_r  <= '0;
            attribute_word_low_r   <= '0;
            attribute_word_high_r   <= '0;
            attribute_crc_enable_r   <= '0;
            caption_control_reg_r <= '0;
            dac_power_down_bits <= PD_RST;
        end else if (bus.wr) begin
            case (bus.addr)
                A_CVBS:   cvbs_r   <= bus.wdata;
                A_SUBCARRIER_PROGRAM_REG: subcarrier_program_reg_r <= bus.wdata;
                A_VIDEO_MODE_REG:   video_mode_reg_r   <= bus.wdata;
                A_AMP:    amp_r    <= bus.wdata;
                A_TEST: begin
                    test_r <= bus.wdata;
                    dac_power_down_bits <= bus.wdata[2:0];
                end
                A_SEL:    sel_r    <= bus.wdata;
                A_COMPONENT_CONTROL_REG:  component_control_reg_r  <= bus.wdata;
                A_ATTRIBUTE_WORD_LOW:   attribute_word_low_r   <= bus.wdata;
                A_ATTRIBUTE_WORD_HIGH:   attribute_word_high_r   <= bus.wdata;
                A_ATTRIBUTE_CRC_ENABLE:   attribute_crc_enable_r   <= bus.wdata;
                A_CAPTION_CONTROL_REG: caption_control_reg_r <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Read port, data one cycle later
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                A_CVBS:   rdata <= cvbs_r;
                A_SUBCARRIER_PROGRAM_REG: rdata <= subcarrier_program_reg_r;
                A_VIDEO_MODE_REG:   rdata <= video_mode_reg_r;
                A_AMP:    rdata <= amp_r;
                A_TEST:   rdata <= test_r;
                A_SEL:    rdata <= sel_r;
                A_COMPONENT_CONTROL_REG:  rdata <= component_control_reg_r;
                A_ATTRIBUTE_WORD_LOW:   rdata <= attribute_word_low_r;
                A_ATTRIBUTE_WORD_HIGH:   rdata <= attribute_word_high_r;
                A_ATTRIBUTE_CRC_ENABLE:   rdata <= attribute_crc_enable_r;
                A_CAPTION_CONTROL_REG: rdata <= caption_control_reg_r;
                A_CAPTION_ODD_DATA:  rdata <= {9'h000, caption_odd_data};
                A_CAPTION_EVEN_DATA:  rdata <= {9'h000, caption_even_data};
                A_STAT:   rdata <= {14'h0000, caption_even_pending, caption_odd_pending};
                default:  rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // Sub-carrier synthesizer, 1024 steps per cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_r      <= PHASE_NTSC;
            phase_pend_r <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == A_VIDEO_MODE_REG)
                phase_r <= bus.wdata[VIDEO_MODE_REG_PAL] ? PHASE_PAL : PHASE_NTSC;
            else if (phase_pend_r && line_go && tim.line == LINE_PHASE && tim.color_field1) begin
                phase_r      <= subcarrier_program_reg_r[9:0];
                phase_pend_r <= 1'b0;
            end else begin
                phase_r <= 10'(phase_r + FREQ_RST);
            end
            if (bus.wr && bus.addr == A_SUBCARRIER_PROGRAM_REG)
                phase_pend_r <= 1'b1;
        end
    end

    // Chroma modulation on the synthesizer quadrant
    always_comb begin
        case (phase_r[9:8])
            2'h0:    c_mod = vin.u;
            2'h1:    c_mod = vin.v;
            2'h2:    c_mod = 10'(-vin.u);
            default: c_mod = 10'(-vin.v);
        endcase
        if (vin.burst)
            c_mod = 10'(-{1'b0, phase_r[9:1]} >> 2);
    end

    // Luma delay line, offset 0 selects index 4, five cycles behind vin.y
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++)
                luma_pipe_r[i] <= '0;
        end else begin
            luma_pipe_r[0] <= vin.y;
            for (int i = 1; i < 8; i++)
                luma_pipe_r[i] <= luma_pipe_r[i-1];
        end
    end
    assign y_cvbs = luma_pipe_r[3'(cvbs_r[6:4] + 3'h4)];
    assign y_cmp  = luma_pipe_r[3'(component_control_reg_r[6:4] + 3'h4)];

    // Build-up ramp length after a blanking edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bld_cnt_r <= '0;
            blank_d_r <= 1'b1;
        end else begin
            blank_d_r <= vin.blank;
            if (vin.blank != blank_d_r)
                bld_cnt_r <= cvbs_r[CVBS_BBLD] ? BLD_BLANK_C : BLD_FAST_C;
            else if (vin.sync != '0 && bld_cnt_r == '0)
                bld_cnt_r <= cvbs_r[CVBS_SBLD] ? BLD_SYNC_C : BLD_FAST_C;
            else if (bld_cnt_r != '0)
                bld_cnt_r <= bld_cnt_r - 6'h01;
        end
    end

    // Edge clipping near blanking transitions
    always_comb begin
        y_shaped = vin.blank ? vin.sync : y_cvbs;
        c_shaped = vin.blank && !vin.burst ? '0 : c_mod;
        if (!cvbs_r[CVBS_SHAPE_DIS] && bld_cnt_r != '0) begin
            y_shaped = y_shaped >> 1;
            c_shaped = c_shaped >>> 1;
        end
    end
    assign sv_c = 10'(c_shaped + CHROMA_MID);

    // Source selection per DAC
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_dac
            logic [3:0]  sel;
            logic [19:0] prod;
            logic [9:0]  code;
            assign sel  = sel_r[4*g +: 4];
            assign prod = {10'h000, amp_r[9:0]} * {10'h000, dac_src[g]} + 20'(GAIN_ROUND);
            always_comb begin
                case (sel)
                    SRC_CVBS: dac_src[g] = 10'(y_shaped + c_shaped);
                    SRC_SY:   dac_src[g] = y_shaped;
                    SRC_SC:   dac_src[g] = sv_c;
                    SRC_YG:   dac_src[g] = y_cmp;
                    SRC_PB:   dac_src[g] = component_control_reg_r[COMPONENT_CONTROL_REG_RGB] ? 10'(y_cmp + vin.u) : vin.u;
                    SRC_PR:   dac_src[g] = component_control_reg_r[COMPONENT_CONTROL_REG_RGB] ? 10'(y_cmp + vin.v) : vin.v;
                    default:  dac_src[g] = CODE_LOW;
                endcase
            end
            always_comb begin
                code = dac_src[g];
                if (test_r[4 + g])
                    code = 10'(prod[19:GAIN_SHIFT] - {5'h00, amp_r[15:10]});
                if (test_r[TEST_DC])
                    code = {test_r[15:8], 2'h0};
                if (!video_mode_reg_r[VIDEO_MODE_REG_VIE])
                    code = CODE_LOW;
            end
            always_ff @(posedge clk) begin
                if (!rst_b)
                    dac_code[10*g +: 10] <= CODE_LOW;
                else
                    dac_code[10*g +: 10] <= code;
            end
        end
    endgenerate

    // Attribute latch on third register write
    always_ff @(posedge clk) begin
        if (!rst_b)
            attr_lat_r <= '0;
        else if (wr_attribute_crc_enable)
            attr_lat_r <= video_mode_reg_r[VIDEO_MODE_REG_PAL] ? {bus.wdata[5:0], attribute_word_high_r[7:0]}
                                           : {attribute_word_high_r[5:0], attribute_word_low_r[7:0]};
    end

    // Caption data and pending flags, set beats clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            caption_odd_data     <= '0;
            caption_even_data    <= '0;
            caption_odd_pending  <= 1'b0;
            caption_even_pending <= 1'b0;
        end else begin
            if (ins_r == INS_CAP && tim.field_odd)
                caption_odd_pending <= 1'b0;
            if (ins_r == INS_CAP && !tim.field_odd)
                caption_even_pending <= 1'b0;
            if (bus.wr && bus.addr == A_CAPTION_ODD_DATA) begin
                caption_odd_data    <= bus.wdata[6:0];
                caption_odd_pending <= 1'b1;
            end
            if (bus.wr && bus.addr == A_CAPTION_EVEN_DATA) begin
                caption_even_data    <= bus.wdata[6:0];
                caption_even_pending <= 1'b1;
            end
        end
    end

    // VBI insertion sequencer
    logic [6:0] cap_ch;
    always_comb begin
        if (tim.field_odd)
            cap_ch = caption_odd_pending ? caption_odd_data : caption_control_reg_r[8:2];
        else
            cap_ch = caption_even_pending ? caption_even_data : caption_control_reg_r[8:2];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ins_r     <= INS_IDLE;
            vbi_word  <= '0;
            vbi_valid <= 1'b0;
            cap_byte  <= '0;
            cap_valid <= 1'b0;
        end else begin
            vbi_valid <= 1'b0;
            cap_valid <= 1'b0;
            case (ins_r)
                INS_IDLE: begin
                    if (line_go && attribute_crc_enable_r[ATTRIBUTE_CRC_ENABLE_EN]) begin
                        if (video_mode_reg_r[VIDEO_MODE_REG_PAL] ? tim.line == LINE_WSS
                            : (tim.line == LINE_ATR_N1 || tim.line == LINE_ATR_N2))
                            ins_r <= INS_ATTR;
                    end
                    if (line_go && !video_mode_reg_r[VIDEO_MODE_REG_PAL] && !video_mode_reg_r[VIDEO_MODE_REG_HD]) begin
                        if ((tim.line == LINE_CAP_ODD && tim.field_odd && caption_control_reg_r[0])
                            || (tim.line == LINE_CAP_EVEN && !tim.field_odd && caption_control_reg_r[1]))
                            ins_r <= INS_CAP;
                    end
                end
                INS_ATTR: begin
                    vbi_word  <= attr_lat_r;
                    vbi_valid <= 1'b1;
                    ins_r     <= INS_IDLE;
                end
                INS_CAP: begin
                    cap_byte  <= {~^cap_ch, cap_ch};
                    cap_valid <= 1'b1;
                    ins_r     <= INS_IDLE;
                end
                default: ins_r <= INS_IDLE;
            endcase
        end
    end

    // Checks
    dis_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        !video_mode_reg_r[VIDEO_MODE_REG_VIE] |=> dac_code == '0)
        else $error("DAC not low while output disabled");
    pd_rst_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> dac_power_down_bits == PD_RST)
        else $error("power down bits not set after reset");
    cap_par_a: assert property (@(posedge clk) disable iff (!rst_b)
        cap_valid |-> ^cap_byte == 1'b1)
        else $error("caption parity not odd");
    cap_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
        ins_r == INS_CAP && tim.field_odd && !(bus.wr && bus.addr == A_CAPTION_ODD_DATA)
        |=> !caption_odd_pending)
        else $error("odd caption flag not cleared");
    cap_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == A_CAPTION_EVEN_DATA |=> caption_even_pending)
        else $error("even caption flag not set");
    atr_lat_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_attribute_crc_enable && !video_mode_reg_r[VIDEO_MODE_REG_PAL] |=> attr_lat_r[7:0] == $past(attribute_word_low_r[7:0]))
        else $error("attribute not latched");
    ph_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        phase_pend_r && line_go && tim.line == LINE_PHASE && tim.color_field1
        && !(bus.wr && bus.addr == A_VIDEO_MODE_REG) |=> phase_r == $past(subcarrier_program_reg_r[9:0]))
        else $error("phase not loaded at line 9");
    dc_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        test_r[TEST_DC] && video_mode_reg_r[VIDEO_MODE_REG_VIE] |=> dac_code[9:0] == {$past(test_r[15:8]), 2'h0})
        else $error("DC level not driven");
    ph_rst_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> phase_r == PHASE_NTSC)
        else $error("reset phase not NTSC preset");
    ph_pal_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == A_VIDEO_MODE_REG && bus.wdata[VIDEO_MODE_REG_PAL] |=> phase_r == PHASE_PAL)
        else $error("PAL preset phase not applied");
    ph_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        !bus.wr && !phase_pend_r |=> phase_r == 10'($past(phase_r) + FREQ_RST))
        else $error("synthesizer phase did not advance");
    edge_clip_a: assert property (@(posedge clk) disable iff (!rst_b)
        !cvbs_r[CVBS_SHAPE_DIS] && bld_cnt_r != '0 |-> !y_shaped[9])
        else $error("edge level not clipped");
    bld_len_a: assert property (@(posedge clk) disable iff (!rst_b)
        vin.blank != blank_d_r
        |=> bld_cnt_r == ($past(cvbs_r[CVBS_BBLD]) ? BLD_BLANK_C : BLD_FAST_C))
        else $error("blanking build-up length wrong");
    sv_mid_a: assert property (@(posedge clk) disable iff (!rst_b)
        c_shaped == '0 |-> sv_c == CHROMA_MID)
        else $error("separate chroma not at mid-scale");
    sel_rsv_a: assert property (@(posedge clk) disable iff (!rst_b)
        sel_r[3:0] > SRC_PR && video_mode_reg_r[VIDEO_MODE_REG_VIE] && !test_r[TEST_DC] && !test_r[4]
        |=> dac_code[9:0] == CODE_LOW)
        else $error("reserved select not low");
    attr_ins_a: assert property (@(posedge clk) disable iff (!rst_b)
        line_go && ins_r == INS_IDLE && attribute_crc_enable_r[ATTRIBUTE_CRC_ENABLE_EN] && !video_mode_reg_r[VIDEO_MODE_REG_PAL]
        && (tim.line == LINE_ATR_N1 || tim.line == LINE_ATR_N2) |=> ##1 vbi_valid)
        else $error("aspect word not inserted");
    wss_ins_a: assert property (@(posedge clk) disable iff (!rst_b)
        line_go && ins_r == INS_IDLE && attribute_crc_enable_r[ATTRIBUTE_CRC_ENABLE_EN] && video_mode_reg_r[VIDEO_MODE_REG_PAL]
        && tim.line == LINE_WSS |=> ##1 vbi_valid)
        else $error("wide-screen word not inserted");
    cap_line_a: assert property (@(posedge clk) disable iff (!rst_b)
        line_go && ins_r == INS_IDLE && !video_mode_reg_r[VIDEO_MODE_REG_PAL] && !video_mode_reg_r[VIDEO_MODE_REG_HD]
        && tim.line == LINE_CAP_ODD && tim.field_odd && caption_control_reg_r[0] |=> ##1 cap_valid)
        else $error("odd caption not sent");
    cap_dflt_a: assert property (@(posedge clk) disable iff (!rst_b)
        ins_r == INS_CAP && tim.field_odd && !caption_odd_pending
        |=> cap_byte[6:0] == $past(caption_control_reg_r[8:2]))
        else $error("default character not sent");
    cap_data_a: assert property (@(posedge clk) disable iff (!rst_b)
        ins_r == INS_CAP && tim.field_odd && caption_odd_pending
        |=> cap_byte[6:0] == $past(caption_odd_data))
        else $error("caption data not sent");

    attr_c: cover property (@(posedge clk) disable iff (!rst_b) vbi_valid);
    cap_c: cover property (@(posedge clk) disable iff (!rst_b) cap_valid && !caption_odd_pending);
    ph_c: cover property (@(posedge clk) disable iff (!rst_b) phase_pend_r ##1 !phase_pend_r);
    dflt_c: cover property (@(posedge clk) disable iff (!rst_b)
        cap_valid && cap_byte[6:0] == caption_control_reg_r[8:2]);
    swing_c: cover property (@(posedge clk) disable iff (!rst_b)
        test_r[4] && video_mode_reg_r[VIDEO_MODE_REG_VIE] && !test_r[TEST_DC]);
endmodule : cvo_stage

// ### verilog/cvo_pkg.sv
// Constants, register map and carrier types for the composite video output stage.
// Assumes a single 100 MHz encoder clock and a simple strobe register port.
package cvo_pkg;
    localparam int        CLK_MHZ        = 100;
    localparam int        BLD_FAST_NS    = 140;
    localparam int        BLD_BLANK_NS   = 300;
    localparam int        BLD_SYNC_NS    = 200;
    localparam int        BLD_FAST_CYC   = (BLD_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int        BLD_BLANK_CYC  = (BLD_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int        BLD_SYNC_CYC   = (BLD_SYNC_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0] BLD_FAST_C    = 6'(BLD_FAST_CYC);
    localparam logic [5:0] BLD_BLANK_C   = 6'(BLD_BLANK_CYC);
    localparam logic [5:0] BLD_SYNC_C    = 6'(BLD_SYNC_CYC);

    localparam logic [9:0] PHASE_NTSC    = 10'h17A;
    localparam logic [9:0] PHASE_PAL     = 10'h164;
    localparam logic [9:0] CHROMA_MID    = 10'h200;
    localparam logic [9:0] CODE_FULL     = 10'h3FF;
    localparam logic [9:0] CODE_LOW      = 10'h000;
    localparam logic [9:0] LINE_PHASE    = 10'h009;
    localparam logic [9:0] LINE_ATR_N1   = 10'h014;
    localparam logic [9:0] LINE_ATR_N2   = 10'h11B;
    localparam logic [9:0] LINE_WSS      = 10'h017;
    localparam logic [9:0] LINE_CAP_ODD  = 10'h015;
    localparam logic [9:0] LINE_CAP_EVEN = 10'h11C;
    localparam logic [9:0] GAIN_RST      = 10'h200;
    localparam int         GAIN_SHIFT    = 9;
    localparam logic [18:0] GAIN_ROUND   = 19'h00100;
    localparam logic [9:0] FREQ_RST      = 10'h001;

    // Register indices
    localparam logic [3:0] A_CVBS    = 4'h0;
    localparam logic [3:0] A_SUBCARRIER_PROGRAM_REG  = 4'h1;
    localparam logic [3:0] A_VIDEO_MODE_REG    = 4'h2;
    localparam logic [3:0] A_AMP     = 4'h3;
    localparam logic [3:0] A_TEST    = 4'h4;
    localparam logic [3:0] A_SEL     = 4'h5;
    localparam logic [3:0] A_COMPONENT_CONTROL_REG   = 4'h6;
    localparam logic [3:0] A_ATTRIBUTE_WORD_LOW    = 4'h7;
    localparam logic [3:0] A_ATTRIBUTE_WORD_HIGH    = 4'h8;
    localparam logic [3:0] A_ATTRIBUTE_CRC_ENABLE    = 4'h9;
    localparam logic [3:0] A_CAPTION_CONTROL_REG  = 4'hA;
    localparam logic [3:0] A_CAPTION_ODD_DATA   = 4'hB;
    localparam logic [3:0] A_CAPTION_EVEN_DATA   = 4'hC;
    localparam logic [3:0] A_STAT    = 4'hD;

    // Field positions
    localparam int CVBS_SHAPE_DIS = 0;
    localparam int CVBS_BBLD      = 1;
    localparam int CVBS_SBLD      = 2;
    localparam int VIDEO_MODE_REG_VIE       = 0;
    localparam int VIDEO_MODE_REG_PAL       = 1;
    localparam int VIDEO_MODE_REG_HD        = 2;
    localparam int TEST_DC        = 3;
    localparam int COMPONENT_CONTROL_REG_RGB      = 0;
    localparam int ATTRIBUTE_CRC_ENABLE_EN        = 7;
    localparam int STAT_ODD       = 0;
    localparam int STAT_EVEN      = 1;
    localparam logic [2:0] PD_RST = 3'h7;

    typedef enum logic [3:0] {
        SRC_CVBS, SRC_SY, SRC_SC, SRC_YG, SRC_PB, SRC_PR
    } src_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [9:0] y;
        logic [9:0] u;
        logic [9:0] v;
        logic [9:0] sync;
        logic       blank;
        logic       burst;
    } vid_in_t;

    typedef struct packed {
        logic [9:0] line;
        logic       field_odd;
        logic       color_field1;
        logic       line_start;
    } timing_t;

    typedef enum logic [1:0] {INS_IDLE, INS_ATTR, INS_CAP} ins_state_t;
endpackage : cvo_pkg

// ### testbench/dac_model.sv
// Model of the three video DACs that the encoder codes feed.
// Assumes codes change on clk; a powered-down channel puts out the low level.
`timescale 1ns/100ps
module dac_model
    import cvo_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [29:0] dac_code,
    input  wire logic [2:0]  dac_power_down_bits,
    output logic [29:0]      dac_level
);
    // Converts each 10-bit code unless that channel is powered down
    always_ff @(posedge clk) begin
        for (int g = 0; g < 3; g++) begin
            if (dac_power_down_bits[g]) begin
                dac_level[10*g +: 10] <= CODE_LOW;
            end else begin
                dac_level[10*g +: 10] <= dac_code[10*g +: 10];
            end
        end
    end
endmodule : dac_model

// ### testbench/tb_composite_video_output_stage.sv
// Self-checking bench for the composite video output stage.
// Assumes the DAC model beside it and register indices from the package.
`timescale 1ns/100ps
module tb_composite_video_output_stage;
    import cvo_pkg::*;
    logic        clk;
    logic        rst_b;
    bus_req_t    bus_q;
    logic [15:0] rdata;
    vid_in_t     vin;
    timing_t     tim;
    logic [29:0] dac_code;
    logic [29:0] dac_level;
    logic [2:0]  pd_bits;
    logic [13:0] vbi_word;
    logic        vbi_valid;
    logic [7:0]  cap_byte;
    logic        cap_valid;
    logic        seen_cap;
    logic        seen_vbi;
    logic [7:0]  cap_q;
    logic [13:0] vbi_q;
    int          mismatches;
    int          tests_run;

    cvo_stage DUT (
        .clk                 (clk),
        .rst_b               (rst_b),
        .bus                 (bus_q),
        .rdata               (rdata),
        .vin                 (vin),
        .tim                 (tim),
        .dac_code            (dac_code),
        .dac_power_down_bits (pd_bits),
        .vbi_word            (vbi_word),
        .vbi_valid           (vbi_valid),
        .cap_byte            (cap_byte),
        .cap_valid           (cap_valid)
    );

    dac_model dacs (
        .clk                 (clk),
        .dac_code            (dac_code),
        .dac_power_down_bits (pd_bits),
        .dac_level           (dac_level)
    );

    always #5 clk = ~clk;

    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_q <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus_q <= '0;
        #1;
        chk({14'h0000, rdata}, {14'h0000, e});
    endtask : rd

    // Pulses a line start and records any caption or attribute output
    task automatic ev(input logic [9:0] ln, input logic odd);
        seen_cap = 1'b0;
        seen_vbi = 1'b0;
        @(posedge clk);
        tim <= '{line: ln, field_odd: odd, color_field1: odd, line_start: 1'b1};
        @(posedge clk);
        tim.line_start <= 1'b0;
        repeat (16) begin
            #1;
            if (cap_valid === 1'b1) begin
                seen_cap = 1'b1;
                cap_q = cap_byte;
            end
            if (vbi_valid === 1'b1) begin
                seen_vbi = 1'b1;
                vbi_q = vbi_word;
            end
            @(posedge clk);
        end
    endtask : ev

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        bus_q = '0;
        vin = '{y: 10'h1F0, u: 10'h000, v: 10'h000, sync: 10'h000, blank: 1'b0, burst: 1'b0};
        tim = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({27'h0, pd_bits}, {27'h0, PD_RST});
        rd(A_STAT, 16'h0000);
        rd(4'hE, 16'h0000);
        repeat (20) @(posedge clk);
        chk(dac_code, {3{CODE_LOW}});
        // DC level 80h scaled by four, all channels powered up
        wr(A_TEST, 16'h8008);
        wr(A_VIDEO_MODE_REG, 16'h0001);
        repeat (20) @(posedge clk);
        chk({27'h0, pd_bits}, 30'h0);
        chk(dac_code, {3{10'h200}});
        chk(dac_level, {3{10'h200}});
        // Gain 578, offset 53 on luma channel 0; chroma and composite beside it
        wr(A_AMP, 16'hD642);
        wr(A_SEL, 16'h0021);
        wr(A_TEST, 16'h0010);
        repeat (20) @(posedge clk);
        chk(dac_code, {10'h1F0, 10'h200, 10'h1FB});
        wr(A_VIDEO_MODE_REG, 16'h0000);
        repeat (20) @(posedge clk);
        chk(dac_code, {3{CODE_LOW}});
        // Captions both fields, default character 20h
        wr(A_CAPTION_CONTROL_REG, 16'h0083);
        wr(A_CAPTION_ODD_DATA, 16'h0041);
        wr(A_CAPTION_EVEN_DATA, 16'h0007);
        rd(A_STAT, 16'h0003);
        ev(LINE_CAP_ODD, 1'b1);
        chk({29'h0, seen_cap}, 30'h1);
        chk({22'h0, cap_q}, 30'h0C1);
        rd(A_STAT, 16'h0002);
        ev(LINE_CAP_EVEN, 1'b0);
        chk({22'h0, cap_q}, 30'h007);
        rd(A_STAT, 16'h0000);
        ev(LINE_CAP_ODD, 1'b1);
        chk({22'h0, cap_q}, 30'h020);
        wr(A_CAPTION_CONTROL_REG, 16'h0082);
        ev(LINE_CAP_ODD, 1'b1);
        chk({28'h0, seen_cap, seen_vbi}, 30'h0);
        // Wide-screen word in PAL mode, enable register written last
        wr(A_VIDEO_MODE_REG, 16'h0003);
        wr(A_ATTRIBUTE_WORD_LOW, 16'h0000);
        wr(A_ATTRIBUTE_WORD_HIGH, 16'h00A5);
        wr(A_ATTRIBUTE_CRC_ENABLE, 16'h00AC);
        ev(LINE_WSS, 1'b1);
        chk({29'h0, seen_vbi}, 30'h1);
        chk({16'h0, vbi_q}, {16'h0, 6'h2C, 8'hA5});
        // Aspect word in NTSC mode on both insertion lines
        wr(A_VIDEO_MODE_REG, 16'h0001);
        wr(A_ATTRIBUTE_WORD_LOW, 16'h0012);
        wr(A_ATTRIBUTE_WORD_HIGH, 16'h0034);
        wr(A_ATTRIBUTE_CRC_ENABLE, 16'h0095);
        ev(LINE_ATR_N1, 1'b1);
        chk({29'h0, seen_vbi}, 30'h1);
        chk({16'h0, vbi_q}, {16'h0, 6'h34, 8'h12});
        ev(LINE_ATR_N2, 1'b0);
        chk({29'h0, seen_vbi}, 30'h1);
        ev(LINE_WSS, 1'b1);
        chk({29'h0, seen_vbi}, 30'h0);
        // New sub-carrier phase taken at line 9 of colour field 1
        wr(A_SUBCARRIER_PROGRAM_REG, 16'h0123);
        ev(LINE_PHASE, 1'b1);
        chk({29'h0, seen_vbi}, 30'h0);
        close_out();
    end
endmodule : tb_composite_video_output_stage
